// [rtl/uhcis_pkg.sv]
package uhcis_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [5:0]  CMD_IDX        = 6'h02;
  localparam logic [5:0]  FLAGS_IDX      = 6'h03;
  // Command/status field layout
  localparam int          CMD_RST_BIT    = 0;
  localparam int          SOC_LSB        = 16;
  localparam int          SOC_MSB        = 17;
  // Event flag positions
  localparam int          FLG_SO         = 0;
  localparam int          FLG_SF         = 2;
  localparam int          FLG_RD         = 3;
  localparam int          FLG_UE         = 4;
  localparam int          FLG_FNO        = 5;
  localparam int          FLG_ROOT_HUB_CHANGE_FLAG       = 6;
  localparam int          FLG_W          = 7;
  localparam logic [6:0]  FLG_VALID      = 7'h7D;
  localparam int          FRAME_MSB      = 15;
  // Reset values
  localparam logic [31:0] CMD_RESET      = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RESET    = 32'h0000_0000;
  localparam logic [1:0]  SOC_RESET      = 2'h0;
  // Soft reset timing: 10 us at 200 MHz, longest time rounds down
  localparam int          CLK_PERIOD_PS  = 5000;
  localparam int          SRST_MAX_NS    = 10000;
  localparam int          SRST_MAX_CYC   = (SRST_MAX_NS * 1000)
                                           / CLK_PERIOD_PS;
  localparam int          SRST_LEN_DEF   = 16;
  localparam int          SRST_CNT_W     = 12;

  typedef enum logic [0:0] {
    SR_IDLE = 1'b0,
    SR_BUSY = 1'b1
  } uhcis_srst_t;

  typedef struct packed {
    uhcis_srst_t           srst;
    logic [SRST_CNT_W-1:0] srst_cnt;
    logic [FLG_W-1:0]      flags;
    logic [1:0]            soc;
    logic [31:0]           hub_prev;
    logic [31:0]           port1_prev;
    logic [31:0]           port2_prev;
    logic                  fn_msb_prev;
    logic                  resume_prev;
    logic                  seen;
    logic                  list_done;
    logic                  halted;
    logic                  irq;
    logic                  sof_tok;
    logic                  suspend;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } uhcis_state_t;
endpackage : uhcis_pkg

// [rtl/uhcis_top.sv]
`timescale 1ns/1ps
// How it works
// - Two-bit overrun count in bits 17:16, starts 00, wraps 11 to 00.
// - Count increments on every overrun, even with the overrun flag set.
// - Software sets bit 0 of command register; soft reset starts then.
// - Soft reset forces suspend state and clears the operational state.
// - Soft reset ends within 10 us; hardware then clears bit 0.
// - Soft reset leaves the root hub alone; no port reset signaling.
// - Each monitored event sets its flag in the event flag register.
// - Interrupt only when flag, its enable and global enable all set.
// - Writing 1 clears a flag, 0 leaves it; software cannot set flags.
// - Event logic only sets flags; only software writes clear them.
// - Flag 6 sets when hub state or either port state changes.
// - Flag 5 sets when frame counter bit 15 toggles either way.
// - Flag 4 on system error, then halt; bit stays 0 by default.
// - Flag 3 on downstream resume start, not on software resume entry.
// - Each frame start sets flag 2; it sends an SOF token only when not halted.
// - Flag 0 sets on schedule overrun; same event bumps the count.
// - Command register writes set bit 0 if written 1, leave it alone if 0; other bits are read-only.
// - Overrun means periodic list not done by the end-of-frame point.
module uhcis_top
  import uhcis_pkg::*;
#(
  parameter int         SRST_LEN  = SRST_LEN_DEF,
  parameter logic       UE_ENABLE = 1'b0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] root_hub_state_reg,
  input  wire logic [31:0] root_port1_state_reg,
  input  wire logic [31:0] root_port2_state_reg,
  input  wire logic [15:0] frame_counter_reg,
  input  wire logic        frame_start,
  input  wire logic        periodic_list_done,
  input  wire logic        eof_point,
  input  wire logic        resume_signal,
  input  wire logic        system_error,
  input  wire logic        error_corrected,
  input  wire logic [6:0]  irq_enable_mask,
  input  wire logic        global_irq_enable,
  output logic             irq_req,
  output logic             sof_token_req,
  output logic             soft_reset_busy,
  output logic             suspend_state_req,
  output logic             halted
);

  uhcis_state_t s_q;
  uhcis_state_t s_d;

  logic        acc_phase;
  logic        acc_done;
  logic        hit_cmd;
  logic        hit_flags;
  logic        wr_cmd;
  logic        wr_flags;
  logic [6:0]  ev_set;
  logic [6:0]  clr_mask;
  logic        overrun;
  logic        srst_start;
  logic        srst_end;
  logic [31:0] cmd_view;
  logic [31:0] flags_view;

  // Bus decode; byte address holds the register index in bits 7:2
  always_comb begin
    acc_phase = psel & penable;
    acc_done  = acc_phase & s_q.pready;
    hit_cmd   = (paddr[7:2] == CMD_IDX) && (paddr[1:0] == 2'h0);
    hit_flags = (paddr[7:2] == FLAGS_IDX) && (paddr[1:0] == 2'h0);
    // Host stays off the bus during soft reset; stray writes dropped
    wr_cmd    = acc_done & pwrite & hit_cmd & pstrb[0]
                & (s_q.srst == SR_IDLE);
    wr_flags  = acc_done & pwrite & hit_flags & pstrb[0]
                & (s_q.srst == SR_IDLE);
  end

  // Readback views, reserved bits held at zero
  always_comb begin
    cmd_view                    = CMD_RESET;
    cmd_view[CMD_RST_BIT]       = (s_q.srst == SR_BUSY);
    cmd_view[SOC_MSB:SOC_LSB]   = s_q.soc;
    flags_view                  = FLAGS_RESET;
    flags_view[FLG_W-1:0]       = s_q.flags & FLG_VALID;
  end

  // Event detection from the surrounding controller
  always_comb begin
    ev_set = 7'h00;
    // Overrun: end of frame reached before the periodic list finished
    overrun = eof_point & ~s_q.list_done & ~periodic_list_done;
    ev_set[FLG_SO] = overrun;
    ev_set[FLG_SF] = frame_start;
    // Only the downstream edge counts; software resume entry is
    // a separate path that never reaches this detector
    ev_set[FLG_RD] = resume_signal & ~s_q.resume_prev;
    ev_set[FLG_UE] = system_error & UE_ENABLE;
    // First cycle after reset has no valid history to compare
    ev_set[FLG_FNO] = s_q.seen
                      & (frame_counter_reg[FRAME_MSB]
                         != s_q.fn_msb_prev);
    ev_set[FLG_ROOT_HUB_CHANGE_FLAG] = s_q.seen
                       & ((root_hub_state_reg != s_q.hub_prev)
                          | (root_port1_state_reg != s_q.port1_prev)
                          | (root_port2_state_reg
                             != s_q.port2_prev));
  end

  // Soft reset start and end
  always_comb begin
    srst_start = wr_cmd & pwdata[CMD_RST_BIT];
    srst_end   = (s_q.srst == SR_BUSY)
                 && (s_q.srst_cnt == SRST_CNT_W'(SRST_LEN - 1));
    // Write-one-to-clear mask; writing 0 changes nothing
    clr_mask   = wr_flags ? (pwdata[FLG_W-1:0] & FLG_VALID)
                          : 7'h00;
  end

  // Next-state logic for the whole block
  always_comb begin
    s_d = s_q;
    // Input history; soft reset keeps it, root hub is untouched
    s_d.hub_prev    = root_hub_state_reg;
    s_d.port1_prev  = root_port1_state_reg;
    s_d.port2_prev  = root_port2_state_reg;
    s_d.fn_msb_prev = frame_counter_reg[FRAME_MSB];
    s_d.resume_prev = resume_signal;
    s_d.seen        = 1'b1;

    // Periodic list progress within the current frame
    if (frame_start) begin
      s_d.list_done = 1'b0;
    end
    if (periodic_list_done) begin
      s_d.list_done = 1'b1;
    end

    // Soft reset sequencer
    s_d.suspend = 1'b0;
    case (s_q.srst)
      SR_IDLE: begin
        if (srst_start) begin
          s_d.srst     = SR_BUSY;
          s_d.srst_cnt = '0;
          s_d.suspend  = 1'b1;
        end
      end
      SR_BUSY: begin
        s_d.srst_cnt = s_q.srst_cnt + SRST_CNT_W'(1);
        if (srst_end) begin
          s_d.srst = SR_IDLE;
        end
      end
      default: begin
        s_d.srst = SR_IDLE;
      end
    endcase

    // Flags: clear by software first, then set by events so set wins
    s_d.flags = s_q.flags & ~clr_mask;
    if (srst_start) begin
      s_d.flags     = 7'h00;
      s_d.list_done = 1'b0;
    end
    s_d.flags = s_d.flags | (ev_set & FLG_VALID);

    // Overrun count, wraps naturally in two bits
    if (srst_start) begin
      s_d.soc = SOC_RESET;
    end
    if (overrun) begin
      s_d.soc = s_d.soc + 2'h1;
    end

    // Halt on system error until corrected or reset
    if (error_corrected | srst_start) begin
      s_d.halted = 1'b0;
    end
    if (ev_set[FLG_UE]) begin
      s_d.halted = 1'b1;
    end

    // Token request and interrupt, both registered
    s_d.sof_tok = frame_start & ~s_q.halted;
    s_d.irq = global_irq_enable
              & |(s_q.flags & irq_enable_mask & FLG_VALID);

    // APB answer: one wait state, pready raised for one cycle
    s_d.pready  = acc_phase & ~s_q.pready;
    s_d.pslverr = 1'b0;
    if (acc_phase & ~s_q.pready) begin
      s_d.pslverr = ~(hit_cmd | hit_flags);
      if (!pwrite && hit_cmd) begin
        s_d.prdata = cmd_view;
      end else if (!pwrite && hit_flags) begin
        s_d.prdata = flags_view;
      end else begin
        s_d.prdata = 32'h0000_0000;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  always_comb begin
    prdata            = s_q.prdata;
    pready            = s_q.pready;
    pslverr           = s_q.pslverr;
    irq_req           = s_q.irq;
    sof_token_req     = s_q.sof_tok;
    soft_reset_busy   = (s_q.srst == SR_BUSY);
    suspend_state_req = s_q.suspend;
    halted            = s_q.halted;
  end

  // Checks next to the logic they guard
  chk_soc_incr: assert property (@(posedge pclk)
    disable iff (!presetn)
    overrun && !srst_start |=> s_q.soc == $past(s_q.soc) + 2'h1)
    else $error("overrun count did not step by one");

  chk_soc_when_set: assert property (@(posedge pclk)
    disable iff (!presetn)
    overrun && s_q.flags[FLG_SO] && !srst_start
      |=> s_q.soc != $past(s_q.soc))
    else $error("overrun count stuck while flag set");

  chk_srst_starts: assert property (@(posedge pclk)
    disable iff (!presetn)
    srst_start |=> soft_reset_busy && suspend_state_req)
    else $error("soft reset did not start");

  chk_srst_clears: assert property (@(posedge pclk)
    disable iff (!presetn)
    srst_start && ev_set == 7'h00 |=> s_q.flags == 7'h00)
    else $error("soft reset left flags set");

  // Check helper: cycles spent busy; saturates so a hang still fires
  logic [SRST_CNT_W-1:0] busy_cyc_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cyc_q <= '0;
    end else if (!soft_reset_busy) begin
      busy_cyc_q <= '0;
    end else if (busy_cyc_q != '1) begin
      busy_cyc_q <= busy_cyc_q + SRST_CNT_W'(1);
    end
  end

  chk_srst_bound: assert property (@(posedge pclk)
    disable iff (!presetn)
    soft_reset_busy |-> busy_cyc_q < SRST_CNT_W'(SRST_MAX_CYC))
    else $error("soft reset ran past ten microseconds");

  chk_srst_len: assert property (@(posedge pclk)
    disable iff (!presetn)
    $fell(soft_reset_busy) |-> busy_cyc_q == SRST_CNT_W'(SRST_LEN))
    else $error("soft reset length differs from setting");

  chk_srst_hub_quiet: assert property (@(posedge pclk)
    disable iff (!presetn)
    soft_reset_busy && !s_q.flags[FLG_ROOT_HUB_CHANGE_FLAG]
      && $stable(root_hub_state_reg) && $stable(root_port1_state_reg)
      && $stable(root_port2_state_reg) |=> !s_q.flags[FLG_ROOT_HUB_CHANGE_FLAG])
    else $error("soft reset disturbed root hub history");

  chk_flag_set: assert property (@(posedge pclk)
    disable iff (!presetn)
    frame_start |=> s_q.flags[FLG_SF])
    else $error("event flag not set");

  chk_irq_gate: assert property (@(posedge pclk)
    disable iff (!presetn)
    ##1 irq_req |-> $past(global_irq_enable)
      && ($past(s_q.flags & irq_enable_mask) != 7'h00))
    else $error("interrupt without flag, enable and global enable");

  chk_w1c: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr_flags && pwdata[FLG_SF] && !frame_start && !srst_start
      |=> !s_q.flags[FLG_SF])
    else $error("write one did not clear flag");

  chk_no_hw_clear: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_q.flags[FLG_RD] && !wr_flags && !srst_start
      |=> s_q.flags[FLG_RD])
    else $error("flag cleared without software write");

  chk_root_hub_change_flag_change: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_q.seen && ($changed(root_hub_state_reg)
      || $changed(root_port1_state_reg)
      || $changed(root_port2_state_reg)) |=> s_q.flags[FLG_ROOT_HUB_CHANGE_FLAG])
    else $error("root hub change flag missed");

  chk_fno_toggle: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_q.seen && $changed(frame_counter_reg[FRAME_MSB])
      |=> s_q.flags[FLG_FNO])
    else $error("frame overflow flag missed");

  chk_ue_quiet: assert property (@(posedge pclk)
    disable iff (!presetn)
    !UE_ENABLE |-> !s_q.flags[FLG_UE] && !halted)
    else $error("error flag or halt with error path off");

  chk_rd_event: assert property (@(posedge pclk)
    disable iff (!presetn)
    $rose(resume_signal) |=> s_q.flags[FLG_RD])
    else $error("resume flag missed");

  chk_sof_token: assert property (@(posedge pclk)
    disable iff (!presetn)
    frame_start && !halted |=> sof_token_req ##0 s_q.flags[FLG_SF])
    else $error("frame start lost token or flag");

  chk_so_flag: assert property (@(posedge pclk)
    disable iff (!presetn)
    eof_point && !periodic_list_done && !s_q.list_done
      |=> s_q.flags[FLG_SO])
    else $error("overrun flag missed");

  chk_cmd_set_only: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr_cmd && !pwdata[CMD_RST_BIT] |=> !soft_reset_busy)
    else $error("zero written to command bit started a reset");

  chk_reserved_zero: assert property (@(posedge pclk)
    disable iff (!presetn)
    pready |-> prdata[31:18] == 14'h0000
      && (prdata[15:7] == 9'h000 || !hit_flags))
    else $error("reserved bits read non-zero");

endmodule : uhcis_top

// [sim/uhcis_host_model.sv]
`timescale 1ns/1ps
// Host processor side: issues APB transfers for the bench
module uhcis_host_model (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        soft_reset_busy,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  // Idle bus from time zero
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end

  // One transfer, held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    // Controller resetting itself: stay off the bus; only the
    // bench's own timeout ends a stuck wait
    while (soft_reset_busy !== 1'h0) begin
      @(posedge pclk);
    end
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
endmodule : uhcis_host_model

// [sim/usb_host_cmd_and_irq_status_tb.sv]
`timescale 1ns/1ps
module usb_host_cmd_and_irq_status_tb;
  import uhcis_pkg::*;
  localparam int         SRST_N = 4;
  localparam logic [7:0] A_CMD  = {CMD_IDX, 2'h0};
  localparam logic [7:0] A_FLG  = {FLAGS_IDX, 2'h0};
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0]  pstrb;
  logic        irq_req, sof_tok, busy, susp, halted;
  logic [31:0] hub = 32'h0, port1 = 32'h0, port2 = 32'h0;
  logic [15:0] fnum = 16'h0;
  logic        fstart = 1'h0, ldone = 1'h0, eof = 1'h0, resume = 1'h0;
  logic        syserr = 1'h0, errfix = 1'h0, gie = 1'h0;
  logic [6:0]  mask = 7'h00;
  int          errors = 0, checked = 0, cyc = 0, n_sof = 0, n_susp = 0;

  uhcis_top #(.SRST_LEN(SRST_N), .UE_ENABLE(1'h0)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .root_hub_state_reg(hub), .root_port1_state_reg(port1),
    .root_port2_state_reg(port2), .frame_counter_reg(fnum),
    .frame_start(fstart), .periodic_list_done(ldone), .eof_point(eof),
    .resume_signal(resume), .system_error(syserr),
    .error_corrected(errfix), .irq_enable_mask(mask),
    .global_irq_enable(gie), .irq_req(irq_req),
    .sof_token_req(sof_tok), .soft_reset_busy(busy),
    .suspend_state_req(susp), .halted(halted));

  uhcis_host_model u_host (
    .pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .soft_reset_busy(busy), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

  always #2.5 pclk = ~pclk;

  // Pulse counters and hang guard
  always @(posedge pclk) begin
    cyc++;
    if (sof_tok === 1'h1) n_sof++;
    if (susp === 1'h1) n_susp++;
    if (cyc == 3000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    u_host.xfer(1'h1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic e;
    u_host.xfer(1'h0, a, 32'h0, rdv, e);
  endtask : rd

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask : tick

  // One frame; list finishes with the end-of-frame point only if asked
  task automatic frame(input logic done);
    @(posedge pclk);
    fstart <= 1'h1;
    @(posedge pclk);
    fstart <= 1'h0;
    ldone <= done;
    eof <= 1'h1;
    @(posedge pclk);
    ldone <= 1'h0;
    eof <= 1'h0;
  endtask : frame

  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    rd(A_CMD); check("cmd reset", rdv, CMD_RESET);
    rd(A_FLG); check("flags reset", rdv, FLAGS_RESET);
    wr(A_CMD, 32'hFFFF_FFFE);
    rd(A_CMD); check("cmd ro bits", rdv, 32'h0);
    u_host.xfer(1'h0, 8'h40, 32'h0, r, e);
    check("unmapped err", {31'h0, e}, 32'h1);
    check("unmapped data", r, 32'h0);
  endtask : t_regs

  task automatic t_overrun();
    int s;
    s = n_sof;
    frame(1'h1);
    rd(A_CMD); check("no overrun", rdv, 32'h0);
    rd(A_FLG); check("sof flag", rdv, 32'h4);
    // Count keeps going while the flag stays set, and wraps
    for (int i = 1; i <= 5; i++) begin
      frame(1'h0);
      rd(A_CMD); check("count", rdv, 32'(i % 4) << 16);
    end
    rd(A_FLG); check("overrun flag", rdv, 32'h5);
    check("sof tokens", n_sof - s, 6);
    wr(A_CMD, 32'h0);
    rd(A_CMD); check("count kept", rdv, 32'h1_0000);
    wr(A_FLG, 32'h1);
    rd(A_FLG); check("w1c bit0", rdv, 32'h4);
    rd(A_CMD); check("count stays", rdv, 32'h1_0000);
  endtask : t_overrun

  task automatic t_events();
    wr(A_FLG, 32'hFFFF_FFFF);
    rd(A_FLG); check("no sw set", rdv, 32'h0);
    @(posedge pclk);
    fnum <= 16'h8000;
    hub <= 32'h101;
    resume <= 1'h1;
    syserr <= 1'h1;
    @(posedge pclk);
    syserr <= 1'h0;
    rd(A_FLG); check("events", rdv, 32'h68);
    check("halted", {31'h0, halted}, 32'h0);
    wr(A_FLG, 32'h60);
    // Bit 15 falls; other counter bits change too
    fnum <= 16'h0FFF;
    port2 <= 32'h1;
    rd(A_FLG); check("again", rdv, 32'h68);
    wr(A_FLG, 32'h7F);
    tick(3);
    rd(A_FLG); check("held resume", rdv, 32'h0);
  endtask : t_events

  task automatic t_irq();
    frame(1'h0);
    mask <= 7'h01;
    tick(3); check("irq gie off", {31'h0, irq_req}, 32'h0);
    gie <= 1'h1;
    tick(3); check("irq on", {31'h0, irq_req}, 32'h1);
    mask <= 7'h40;
    tick(3); check("irq masked", {31'h0, irq_req}, 32'h0);
    mask <= 7'h04;
    tick(3); check("irq sof", {31'h0, irq_req}, 32'h1);
    wr(A_FLG, 32'h4);
    tick(3); check("irq cleared", {31'h0, irq_req}, 32'h0);
  endtask : t_irq

  task automatic t_srst();
    int s;
    frame(1'h0);
    s = n_susp;
    wr(A_CMD, 32'h1);
    #1 check("busy", {31'h0, busy}, 32'h1);
    tick(SRST_N - 1);
    #1 check("busy held", {31'h0, busy}, 32'h1);
    tick(2);
    #1 check("busy done", {31'h0, busy}, 32'h0);
    check("suspend", n_susp - s, 1);
    rd(A_CMD); check("cmd cleared", rdv, 32'h0);
    rd(A_FLG); check("flags cleared", rdv, 32'h0);
  endtask : t_srst

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_overrun();
    t_events();
    t_irq();
    t_srst();
    give_verdict();
  end
endmodule : usb_host_cmd_and_irq_status_tb
